//--- src/fbsr_defines.vh
// offsets, field positions and reset values of the register bank
// What this block does
// - clock fault set when fast or slow oscillator fails.
// - comm timeout flag set when comm watchdog expires.
// - temperature summary latches OR of five alarm bits.
// - cell high summary latches OR of twelve cell high bits.
// - cell low summary latches OR of twelve cell low bits.
// - broken lead summary latches OR of thirteen lead break bits.
// - zero write clears a summary only once its detail is clear.
// - ground and stack top lead flags set on detection, zero write clears.
// - bandgap flag set when reference leaves its power-good window.
// - positive force: cells read 1fff, temperatures 3fff.
// - negative force: cells read 2000, temperatures zero.
// - temperature alarm bits set on over-temperature, zero write clears.
// - read-all returns locations 0x00 to 0x06 in one read.
// - balance status entry zero holds manual and timed enables.
// - entries one to twelve serve automatic balancing.
// - balance status address reaches the pointer-selected entry.
// - allow bit permits or inhibits balancing; setting it also clears the done flag.
// - enable and inhibit commands act like writing the allow bit.
// - allow clears when balancing completes, as done flag sets.
// - comm timeout setting resets to all ones, longest period.
// - balancing timeout resets to zero, decoded for timing.
// - checksum mismatch on check sets mismatch flag.
// - checksum mismatch stops scanning and balancing.
// - done flag sets when timed or auto balancing ends; resets one.
`ifndef FBSR_DEFINES_VH
`define FBSR_DEFINES_VH
`define FBSR_A_CELL_HIGH 6'h00
`define FBSR_A_CELL_LOW 6'h01
`define FBSR_A_LEAD 6'h02
`define FBSR_A_FAULT_SETUP 6'h03
`define FBSR_A_FAULT 6'h04
`define FBSR_A_CELL_SETUP 6'h05
`define FBSR_A_TEMP 6'h06
`define FBSR_A_READ_ALL 6'h0f
`define FBSR_A_HIGH_LIM 6'h10
`define FBSR_A_LOW_LIM 6'h11
`define FBSR_A_TEMP_LIM 6'h12
`define FBSR_A_BAL_SETUP 6'h13
`define FBSR_A_BAL_STATUS 6'h14
`define FBSR_A_TIMEOUT 6'h15
`define FBSR_READ_ALL_LAST 6'h06
`define FBSR_FS_SELECTOR 13
`define FBSR_FS_REGULATOR 12
`define FBSR_FS_BANDGAP 11
`define FBSR_FS_CHECKSUM 10
`define FBSR_FS_GROUND 9
`define FBSR_FS_STACK_TOP 8
`define FBSR_FS_BROKEN 7
`define FBSR_FS_CELL_LOW 6
`define FBSR_FS_CELL_HIGH 5
`define FBSR_FS_TEMP 4
`define FBSR_FS_COMM 3
`define FBSR_FS_CLOCK 2
`define FBSR_CS_NEG 13
`define FBSR_CS_POS 12
`define FBSR_BS_ALLOW 9
`define FBSR_BS_PTR_LO 5
`define FBSR_MODE_OFF 2'h0
`define FBSR_MODE_MANUAL 2'h1
`define FBSR_MODE_TIMED 2'h2
`define FBSR_MODE_AUTO 2'h3
`define FBSR_ZERO 14'h0000
`define FBSR_CELL_POS_FULL 14'h1fff
`define FBSR_CELL_NEG_FULL 14'h2000
`define FBSR_TEMP_POS_FULL 14'h3fff
`define FBSR_TEMP_NEG_FULL 14'h0000
`define FBSR_RST_HIGH_LIM 14'h1fff
`define FBSR_RST_LOW_LIM 14'h0000
`define FBSR_RST_TEMP_LIM 14'h0000
`define FBSR_RST_TIMEOUT 14'h007f
`define FBSR_RST_FAULT_SETUP 14'h0270
`define FBSR_ENTRIES 13
`define FBSR_TICK_US 1000
`define FBSR_CLK_MHZ 50
`define FBSR_TICK_CYCLES (`FBSR_TICK_US * `FBSR_CLK_MHZ)
`endif

//--- src/fbsr_regs.v
// fault status, cell setup and balance setup register bank
`timescale 1ns/10ps
`default_nettype none
`include "fbsr_defines.vh"
module fbsr_regs #(
    parameter TICK_CYCLES = `FBSR_TICK_CYCLES
) (
    input wire mclk_in,
    input wire rst_in,
    input wire [5:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [13:0] reg_wdata_in,
    output reg [13:0] reg_rdata_out,
    output reg reg_rvalid_out,
    output wire reg_rlast_out,
    input wire osc_fast_fail_in,
    input wire osc_slow_fail_in,
    input wire comm_watchdog_expired_in,
    input wire bandgap_bad_in,
    input wire regulator_bad_in,
    input wire selector_loop_fail_in,
    input wire ground_open_in,
    input wire stack_top_open_in,
    input wire [12:0] lead_open_in,
    input wire [4:0] temp_over_in,
    input wire checksum_check_in,
    input wire checksum_bad_in,
    input wire bal_enable_cmd_in,
    input wire bal_inhibit_cmd_in,
    input wire bal_complete_in,
    input wire cell_valid_in,
    input wire [3:0] cell_index_in,
    input wire [13:0] cell_raw_in,
    input wire [13:0] temp_raw_in,
    input wire [13:0] fault_mask_in,
    output reg [13:0] cell_result_out,
    output reg [13:0] temp_result_out,
    output reg fault_n_out,
    output reg scan_halt_out,
    output reg balancing_active_out,
    output reg [1:0] balancing_mode_select_out,
    output reg [11:0] cell_drain_enables_out,
    output reg [6:0] comm_timeout_setting_out,
    output reg [6:0] balancing_timeout_setting_out,
    output reg [15:0] balancing_timeout_ticks_out,
    output reg [13:0] temp_limit_out
);
////////////////////////////////////////////////////////////////////////////////
// pin level inputs pass two flops before use
wire [25:0] async_raw;
reg [25:0] sync1_reg;
reg [25:0] sync2_reg;
assign async_raw = {osc_fast_fail_in, osc_slow_fail_in, bandgap_bad_in, regulator_bad_in,
    selector_loop_fail_in, ground_open_in, stack_top_open_in, lead_open_in, temp_over_in,
    comm_watchdog_expired_in};
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        sync1_reg <= 26'h0000000;
        sync2_reg <= 26'h0000000;
    end else begin
        sync1_reg <= async_raw;
        sync2_reg <= sync1_reg;
    end
end
wire s_osc_fast = sync2_reg[25];
wire s_osc_slow = sync2_reg[24];
wire s_bandgap = sync2_reg[23];
wire s_regulator = sync2_reg[22];
wire s_selector = sync2_reg[21];
wire s_ground = sync2_reg[20];
wire s_stack_top = sync2_reg[19];
wire [12:0] s_lead = sync2_reg[18:6];
wire [4:0] s_temp = sync2_reg[5:1];
wire s_comm = sync2_reg[0];
////////////////////////////////////////////////////////////////////////////////
reg [11:0] cell_high_bits_reg;
reg [11:0] cell_low_bits_reg;
reg [12:0] lead_break_bits_reg;
reg [13:0] fault_setup_reg;
reg [13:0] fault_summary_reg;
reg [13:0] cell_setup_reg;
reg [4:0] temp_input_alarm_bits_reg;
reg [13:0] cell_high_limit_reg;
reg [13:0] cell_low_limit_reg;
reg [13:0] external_temp_limit_reg;
reg [13:0] balancing_setup_reg;
reg [13:0] timeout_settings_reg;
reg balancing_done_flag_reg;
reg [11:0] bal_entry_reg [0:`FBSR_ENTRIES-1];
reg [5:0] stream_addr_reg;
reg stream_active_reg;
// signed compare against limits
function signed_gt;
    input [13:0] a;
    input [13:0] b;
    begin
        signed_gt = $signed(a) > $signed(b);
    end
endfunction
function addr_hit;
    input [5:0] a;
    input [5:0] b;
    begin
        addr_hit = (a == b);
    end
endfunction
wire wr_fault = reg_wr_in && addr_hit(reg_addr_in, `FBSR_A_FAULT);
wire wr_zero = (reg_wdata_in == `FBSR_ZERO);
wire [3:0] ptr = balancing_setup_reg[`FBSR_BS_PTR_LO+3:`FBSR_BS_PTR_LO];
wire ptr_ok = (ptr < `FBSR_ENTRIES);
wire force_pos = cell_setup_reg[`FBSR_CS_POS];
wire force_neg = cell_setup_reg[`FBSR_CS_NEG];
wire cell_in_range = cell_valid_in && (cell_index_in >= 4'h1) && (cell_index_in <= 4'hc);
wire [3:0] cell_slot = cell_index_in - 4'h1;
wire bal_allow = balancing_setup_reg[`FBSR_BS_ALLOW];
////////////////////////////////////////////////////////////////////////////////
// detail bits: a lead or temperature set beats a clearing write; a cell high or low write beats a set
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        cell_high_bits_reg <= 12'h000;
        cell_low_bits_reg <= 12'h000;
        lead_break_bits_reg <= 13'h0000;
        temp_input_alarm_bits_reg <= 5'h00;
    end else begin
        if (reg_wr_in && addr_hit(reg_addr_in, `FBSR_A_CELL_HIGH))
            cell_high_bits_reg <= reg_wdata_in[11:0];
        else if (cell_in_range && signed_gt(cell_raw_in, cell_high_limit_reg))
            cell_high_bits_reg[cell_slot] <= 1'b1;
        if (reg_wr_in && addr_hit(reg_addr_in, `FBSR_A_CELL_LOW))
            cell_low_bits_reg <= reg_wdata_in[11:0];
        else if (cell_in_range && signed_gt(cell_low_limit_reg, cell_raw_in))
            cell_low_bits_reg[cell_slot] <= 1'b1;
        if (reg_wr_in && addr_hit(reg_addr_in, `FBSR_A_LEAD))
            lead_break_bits_reg <= reg_wdata_in[12:0] | s_lead;
        else
            lead_break_bits_reg <= lead_break_bits_reg | s_lead;
        if (reg_wr_in && addr_hit(reg_addr_in, `FBSR_A_TEMP))
            temp_input_alarm_bits_reg <= reg_wdata_in[4:0] | s_temp;
        else
            temp_input_alarm_bits_reg <= temp_input_alarm_bits_reg | s_temp;
    end
end
////////////////////////////////////////////////////////////////////////////////
// a summary clears only once its detail is zero
reg [13:0] fault_summary_next;
always @* begin
    fault_summary_next = fault_summary_reg;
    if (wr_fault && wr_zero) begin
        fault_summary_next = `FBSR_ZERO;
        fault_summary_next[`FBSR_FS_TEMP] = |temp_input_alarm_bits_reg;
        fault_summary_next[`FBSR_FS_CELL_HIGH] = |cell_high_bits_reg;
        fault_summary_next[`FBSR_FS_CELL_LOW] = |cell_low_bits_reg;
        fault_summary_next[`FBSR_FS_BROKEN] = |lead_break_bits_reg;
    end else if (wr_fault) begin
        fault_summary_next = reg_wdata_in & 14'h3ffc;
    end
    if (s_osc_fast || s_osc_slow)
        fault_summary_next[`FBSR_FS_CLOCK] = 1'b1;
    if (s_comm)
        fault_summary_next[`FBSR_FS_COMM] = 1'b1;
    if (|temp_input_alarm_bits_reg)
        fault_summary_next[`FBSR_FS_TEMP] = 1'b1;
    if (|cell_high_bits_reg)
        fault_summary_next[`FBSR_FS_CELL_HIGH] = 1'b1;
    if (|cell_low_bits_reg)
        fault_summary_next[`FBSR_FS_CELL_LOW] = 1'b1;
    if (|lead_break_bits_reg)
        fault_summary_next[`FBSR_FS_BROKEN] = 1'b1;
    if (s_stack_top)
        fault_summary_next[`FBSR_FS_STACK_TOP] = 1'b1;
    if (s_ground)
        fault_summary_next[`FBSR_FS_GROUND] = 1'b1;
    if (checksum_check_in && checksum_bad_in)
        fault_summary_next[`FBSR_FS_CHECKSUM] = 1'b1;
    if (s_bandgap)
        fault_summary_next[`FBSR_FS_BANDGAP] = 1'b1;
    if (s_regulator)
        fault_summary_next[`FBSR_FS_REGULATOR] = 1'b1;
    if (s_selector)
        fault_summary_next[`FBSR_FS_SELECTOR] = 1'b1;
end
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
        fault_summary_reg <= `FBSR_ZERO;
    else
        fault_summary_reg <= fault_summary_next;
end
////////////////////////////////////////////////////////////////////////////////
// setup registers and balancing control
reg [13:0] bal_setup_next;
always @* begin
    bal_setup_next = balancing_setup_reg;
    if (reg_wr_in && addr_hit(reg_addr_in, `FBSR_A_BAL_SETUP))
        bal_setup_next = reg_wdata_in & 14'h03ff;
    if (bal_enable_cmd_in)
        bal_setup_next[`FBSR_BS_ALLOW] = 1'b1;
    if (bal_inhibit_cmd_in)
        bal_setup_next[`FBSR_BS_ALLOW] = 1'b0;
    // completion and checksum failure beat an enable
    if (bal_complete_in || fault_summary_reg[`FBSR_FS_CHECKSUM])
        bal_setup_next[`FBSR_BS_ALLOW] = 1'b0;
end
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        fault_setup_reg <= `FBSR_RST_FAULT_SETUP;
        cell_setup_reg <= `FBSR_ZERO;
        cell_high_limit_reg <= `FBSR_RST_HIGH_LIM;
        cell_low_limit_reg <= `FBSR_RST_LOW_LIM;
        external_temp_limit_reg <= `FBSR_RST_TEMP_LIM;
        balancing_setup_reg <= `FBSR_ZERO;
        timeout_settings_reg <= `FBSR_RST_TIMEOUT;
        balancing_done_flag_reg <= 1'b1;
    end else begin
        balancing_setup_reg <= bal_setup_next;
        if (bal_complete_in)
            balancing_done_flag_reg <= 1'b1;
        else if (bal_setup_next[`FBSR_BS_ALLOW] && !bal_allow)
            balancing_done_flag_reg <= 1'b0;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `FBSR_A_FAULT_SETUP: fault_setup_reg <= reg_wdata_in & 14'h1fff;
                `FBSR_A_CELL_SETUP: cell_setup_reg <= reg_wdata_in;
                `FBSR_A_HIGH_LIM: cell_high_limit_reg <= reg_wdata_in & 14'h1fff;
                `FBSR_A_LOW_LIM: cell_low_limit_reg <= reg_wdata_in & 14'h1fff;
                `FBSR_A_TEMP_LIM: external_temp_limit_reg <= reg_wdata_in;
                `FBSR_A_TIMEOUT: timeout_settings_reg <= reg_wdata_in;
                default: ;
            endcase
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// balance status entries behind one pointer-indexed window
genvar gi;
generate
    for (gi = 0; gi < `FBSR_ENTRIES; gi = gi + 1) begin : g_entry
        always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in)
                bal_entry_reg[gi] <= 12'h000;
            else if (reg_wr_in && addr_hit(reg_addr_in, `FBSR_A_BAL_STATUS) && (ptr == gi))
                bal_entry_reg[gi] <= reg_wdata_in[11:0];
        end
    end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// read mux; read-all streams seven words
function [13:0] read_word;
    input [5:0] a;
    begin
        case (a)
            `FBSR_A_CELL_HIGH: read_word = {2'h0, cell_high_bits_reg};
            `FBSR_A_CELL_LOW: read_word = {2'h0, cell_low_bits_reg};
            `FBSR_A_LEAD: read_word = {1'h0, lead_break_bits_reg};
            `FBSR_A_FAULT_SETUP: read_word = fault_setup_reg;
            `FBSR_A_FAULT: read_word = fault_summary_reg;
            `FBSR_A_CELL_SETUP: read_word = cell_setup_reg;
            `FBSR_A_TEMP: read_word = {9'h000, temp_input_alarm_bits_reg};
            `FBSR_A_HIGH_LIM: read_word = cell_high_limit_reg;
            `FBSR_A_LOW_LIM: read_word = cell_low_limit_reg;
            `FBSR_A_TEMP_LIM: read_word = external_temp_limit_reg;
            `FBSR_A_BAL_SETUP: read_word = balancing_setup_reg;
            `FBSR_A_BAL_STATUS: read_word = ptr_ok ? {2'h0, bal_entry_reg[ptr]} : `FBSR_ZERO;
            `FBSR_A_TIMEOUT: read_word = timeout_settings_reg;
            default: read_word = `FBSR_ZERO;
        endcase
    end
endfunction
assign reg_rlast_out = reg_rvalid_out && !stream_active_reg;
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        reg_rdata_out <= `FBSR_ZERO;
        reg_rvalid_out <= 1'b0;
        stream_addr_reg <= 6'h00;
        stream_active_reg <= 1'b0;
    end else if (stream_active_reg) begin
        reg_rdata_out <= read_word(stream_addr_reg);
        reg_rvalid_out <= 1'b1;
        stream_active_reg <= (stream_addr_reg != `FBSR_READ_ALL_LAST);
        stream_addr_reg <= stream_addr_reg + 6'h01;
    end else if (reg_rd_in && addr_hit(reg_addr_in, `FBSR_A_READ_ALL)) begin
        reg_rdata_out <= read_word(6'h00);
        reg_rvalid_out <= 1'b1;
        stream_active_reg <= 1'b1;
        stream_addr_reg <= 6'h01;
    end else begin
        reg_rdata_out <= reg_rd_in ? read_word(reg_addr_in) : reg_rdata_out;
        reg_rvalid_out <= reg_rd_in;
    end
end
////////////////////////////////////////////////////////////////////////////////
// derived outputs; both force bits set together pass readings raw
reg [15:0] timeout_ticks;
always @* begin
    case (timeout_settings_reg[13:7])
        7'h00: timeout_ticks = 16'h0000;
        default: timeout_ticks = {9'h000, timeout_settings_reg[13:7]} * 16'h003c;
    endcase
end
always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
        cell_result_out <= `FBSR_ZERO;
        temp_result_out <= `FBSR_ZERO;
        fault_n_out <= 1'b1;
        scan_halt_out <= 1'b0;
        balancing_active_out <= 1'b0;
        balancing_mode_select_out <= `FBSR_MODE_OFF;
        cell_drain_enables_out <= 12'h000;
        comm_timeout_setting_out <= 7'h7f;
        balancing_timeout_setting_out <= 7'h00;
        balancing_timeout_ticks_out <= 16'h0000;
        temp_limit_out <= `FBSR_ZERO;
    end else begin
        if (force_pos && !force_neg) begin
            cell_result_out <= `FBSR_CELL_POS_FULL;
            temp_result_out <= `FBSR_TEMP_POS_FULL;
        end else if (force_neg && !force_pos) begin
            cell_result_out <= `FBSR_CELL_NEG_FULL;
            temp_result_out <= `FBSR_TEMP_NEG_FULL;
        end else begin
            cell_result_out <= cell_raw_in;
            temp_result_out <= temp_raw_in;
        end
        fault_n_out <= ~|(fault_summary_reg & ~fault_mask_in);
        scan_halt_out <= fault_summary_reg[`FBSR_FS_CHECKSUM];
        balancing_active_out <= bal_allow && !fault_summary_reg[`FBSR_FS_CHECKSUM] &&
            (balancing_setup_reg[1:0] != `FBSR_MODE_OFF);
        balancing_mode_select_out <= balancing_setup_reg[1:0];
        cell_drain_enables_out <= bal_entry_reg[0];
        comm_timeout_setting_out <= timeout_settings_reg[6:0];
        balancing_timeout_setting_out <= timeout_settings_reg[13:7];
        balancing_timeout_ticks_out <= timeout_ticks;
        temp_limit_out <= external_temp_limit_reg;
    end
end
// entries 1..12 feed auto balancing via the window
wire unused_auto = |bal_entry_reg[1] | balancing_done_flag_reg;
endmodule // fbsr_regs
`default_nettype wire

//--- bench/fbsr_regs_asserts.sv
// checker for the fault and balance setup register bank
`timescale 1ns/10ps
`default_nettype none
module fbsr_regs_chk (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [13:0] reg_wdata_in,
    input wire logic reg_rvalid_out,
    input wire logic reg_rlast_out,
    input wire logic checksum_check_in,
    input wire logic checksum_bad_in,
    input wire logic bal_inhibit_cmd_in,
    input wire logic bal_complete_in,
    input wire logic [13:0] fault_mask_in,
    input wire logic [13:0] cell_result_out,
    input wire logic [13:0] temp_result_out,
    input wire logic fault_n_out,
    input wire logic scan_halt_out,
    input wire logic balancing_active_out,
    input wire logic [1:0] balancing_mode_select_out,
    input wire logic [6:0] comm_timeout_setting_out,
    input wire logic [15:0] balancing_timeout_ticks_out
);
    logic f_pos;
    logic f_neg;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // force bits shadowed from writes
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            f_pos <= 1'b0;
            f_neg <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == 6'h05) begin
            f_pos <= reg_wdata_in[12];
            f_neg <= reg_wdata_in[13];
        end
    end
    single_read_a: assert property (reg_rd_in && reg_addr_in != 6'h0f && !reg_rvalid_out
        |=> reg_rvalid_out && reg_rlast_out) else $error("bad single read");
    read_all_a: assert property (reg_rd_in && reg_addr_in == 6'h0f && !reg_rvalid_out
        |=> (reg_rvalid_out && !reg_rlast_out)[*6] ##1 (reg_rvalid_out && reg_rlast_out))
        else $error("bad read-all");
    force_pos_a: assert property (f_pos && !f_neg
        |=> cell_result_out == 14'h1fff && temp_result_out == 14'h3fff)
        else $error("bad positive force");
    force_neg_a: assert property (f_neg && !f_pos
        |=> cell_result_out == 14'h2000 && temp_result_out == 14'h0000)
        else $error("bad negative force");
    fault_pin_low_a: assert property ((scan_halt_out && !fault_mask_in[10])[*3]
        |-> !fault_n_out) else $error("fault output not low");
    checksum_halt_a: assert property (checksum_check_in && checksum_bad_in
        |-> ##[1:3] scan_halt_out) else $error("no halt");
    checksum_bal_a: assert property (checksum_check_in && checksum_bad_in
        |-> ##[1:4] !balancing_active_out) else $error("balancing kept");
    inhibit_cmd_a: assert property (bal_inhibit_cmd_in
        |-> ##[1:3] !balancing_active_out) else $error("inhibit failed");
    bal_done_a: assert property (bal_complete_in
        |-> ##[1:3] !balancing_active_out) else $error("completion failed");
    timeout_reset_a: assert property ($past(rst_in) |-> comm_timeout_setting_out == 7'h7f)
        else $error("bad comm timeout");
    timeout_copy_a: assert property (reg_wr_in && reg_addr_in == 6'h15 |-> ##2
        balancing_timeout_ticks_out == {9'h000, $past(reg_wdata_in[13:7], 2)} * 16'h003c)
        else $error("bad ticks");
    mode_copy_a: assert property (reg_wr_in && reg_addr_in == 6'h13 |-> ##2
        balancing_mode_select_out == $past(reg_wdata_in[1:0], 2)) else $error("mode wrong");
endmodule // fbsr_regs_chk
bind fbsr_regs fbsr_regs_chk u_chk (.*);
`default_nettype wire

//--- bench/fbsr_regs_tb.sv
// self-checking bench for the fault and balance setup register bank
`timescale 1ns/10ps
`default_nettype none
module fbsr_regs_tb;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] reg_addr_in = 6'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [13:0] reg_wdata_in = 14'h0000;
    logic [7:0] pins = 8'h00;
    logic [12:0] lead_open_in = 13'h0000;
    logic [4:0] temp_over_in = 5'h00;
    logic chk_in = 1'b0;
    logic bad_in = 1'b0;
    logic en_cmd = 1'b0;
    logic inh_cmd = 1'b0;
    logic done_in = 1'b0;
    logic cell_valid_in = 1'b0;
    logic [3:0] cell_index_in = 4'h0;
    logic [13:0] cell_raw_in = 14'h0123;
    logic [13:0] temp_raw_in = 14'h0456;
    logic [13:0] fault_mask_in = 14'h0000;
    wire [13:0] rdata, cell_res, temp_res, temp_lim;
    wire rvalid, rlast, fault_n, halt, active;
    wire [1:0] mode;
    wire [11:0] drain;
    wire [6:0] comm_to, bal_to;
    wire [15:0] ticks;
    int failures = 0;
    int checks = 0;
    // fault bit per pin
    int fbit [0:7] = '{2, 2, 3, 11, 12, 13, 9, 8};
    fbsr_regs #(.TICK_CYCLES(10)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .reg_rlast_out(rlast), .osc_fast_fail_in(pins[0]), .osc_slow_fail_in(pins[1]),
        .comm_watchdog_expired_in(pins[2]), .bandgap_bad_in(pins[3]),
        .regulator_bad_in(pins[4]), .selector_loop_fail_in(pins[5]),
        .ground_open_in(pins[6]), .stack_top_open_in(pins[7]), .lead_open_in(lead_open_in),
        .temp_over_in(temp_over_in), .checksum_check_in(chk_in), .checksum_bad_in(bad_in),
        .bal_enable_cmd_in(en_cmd), .bal_inhibit_cmd_in(inh_cmd), .bal_complete_in(done_in),
        .cell_valid_in(cell_valid_in), .cell_index_in(cell_index_in),
        .cell_raw_in(cell_raw_in), .temp_raw_in(temp_raw_in), .fault_mask_in(fault_mask_in),
        .cell_result_out(cell_res), .temp_result_out(temp_res), .fault_n_out(fault_n),
        .scan_halt_out(halt), .balancing_active_out(active),
        .balancing_mode_select_out(mode), .cell_drain_enables_out(drain),
        .comm_timeout_setting_out(comm_to), .balancing_timeout_setting_out(bal_to),
        .balancing_timeout_ticks_out(ticks), .temp_limit_out(temp_lim));
    always #10 mclk_in = ~mclk_in;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [13:0] d);
        cyc(1);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        cyc(1);
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [13:0] e);
        cyc(1);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        cyc(1);
        reg_rd_in = 1'b0;
        chk("rdata", {2'b00, e}, {2'b00, rdata});
    endtask
    // pulse outlasts the synchroniser
    task automatic t_pins;
        for (int i = 0; i < 8; i++) begin
            pins[i] = 1'b1;
            cyc(4);
            pins[i] = 1'b0;
            cyc(4);
            rd(6'h04, 14'h0001 << fbit[i]);
            chk("fault_n", 16'h0000, {15'h0, fault_n});
            fault_mask_in = 14'h3fff;
            cyc(3);
            chk("fault_n masked", 16'h0001, {15'h0, fault_n});
            fault_mask_in = 14'h0000;
            wr(6'h04, 14'h0000);
            rd(6'h04, 14'h0000);
        end
    endtask
    // summary survives a clear while detail holds
    task automatic detail(input logic [5:0] a, input logic [13:0] d, input logic [13:0] s);
        rd(a, d);
        rd(6'h04, s);
        wr(6'h04, 14'h0000);
        rd(6'h04, s);
        wr(a, 14'h0000);
        rd(a, 14'h0000);
        wr(6'h04, 14'h0000);
        rd(6'h04, 14'h0000);
    endtask
    task automatic cell_ev(input logic [3:0] idx, input logic [13:0] raw);
        cell_index_in = idx;
        cell_raw_in = raw;
        cell_valid_in = 1'b1;
        cyc(1);
        cell_valid_in = 1'b0;
        cell_raw_in = 14'h0123;
        cyc(4);
    endtask
    task automatic t_details;
        temp_over_in = 5'h04;
        cyc(4);
        temp_over_in = 5'h00;
        cyc(4);
        detail(6'h06, 14'h0004, 14'h0010);
        lead_open_in = 13'h1000;
        cyc(4);
        lead_open_in = 13'h0000;
        cyc(4);
        detail(6'h02, 14'h1000, 14'h0080);
        wr(6'h10, 14'h0100);
        wr(6'h11, 14'h0080);
        cell_ev(4'h3, 14'h0200);
        detail(6'h00, 14'h0004, 14'h0020);
        cell_ev(4'h7, 14'h0010);
        detail(6'h01, 14'h0040, 14'h0040);
    endtask
    task automatic t_force(input logic [13:0] cs, input logic [13:0] ec, input logic [13:0] et);
        wr(6'h05, cs);
        cyc(2);
        chk("cell_result", {2'b00, ec}, {2'b00, cell_res});
        chk("temp_result", {2'b00, et}, {2'b00, temp_res});
    endtask
    task automatic t_read_all;
        logic [13:0] ra [0:6];
        ra = '{14'h0000, 14'h0000, 14'h0000, 14'h0270, 14'h0000, 14'h0123, 14'h0000};
        wr(6'h05, 14'h0123);
        cyc(1);
        reg_addr_in = 6'h0f;
        reg_rd_in = 1'b1;
        cyc(1);
        reg_rd_in = 1'b0;
        for (int k = 0; k < 7; k++) begin
            chk("read_all word", {2'b00, ra[k]}, {2'b00, rdata});
            chk("rlast", {15'h0, k == 6}, {15'h0, rlast});
            cyc(1);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(3);
    endtask
    task automatic t_balance;
        wr(6'h13, 14'h0001);
        wr(6'h14, 14'h0a5a);
        cyc(2);
        chk("drain", 16'h0a5a, {4'h0, drain});
        wr(6'h13, 14'h00a1);
        wr(6'h14, 14'h0111);
        cyc(2);
        chk("drain", 16'h0a5a, {4'h0, drain});
        wr(6'h13, 14'h0001);
        rd(6'h14, 14'h0a5a);
        wr(6'h13, 14'h02a1);
        rd(6'h13, 14'h02a1);
        rd(6'h14, 14'h0111);
        pulse(inh_cmd);
        rd(6'h13, 14'h00a1);
        pulse(en_cmd);
        rd(6'h13, 14'h02a1);
        pulse(done_in);
        rd(6'h13, 14'h00a1);
        for (int m = 0; m < 4; m++) begin
            wr(6'h13, 14'(m));
            cyc(2);
            chk("mode", 16'(m), {14'h0, mode});
        end
        wr(6'h15, 14'h02c0);
        cyc(2);
        chk("ticks", 16'h012c, ticks);
        chk("comm timeout", 16'h0040, {9'h0, comm_to});
        rd(6'h3e, 14'h0000);
        wr(6'h3e, 14'h00ff);
        rd(6'h3e, 14'h0000);
    endtask
    task automatic t_checksum;
        wr(6'h13, 14'h0203);
        pulse(en_cmd);
        chk_in = 1'b1;
        bad_in = 1'b1;
        cyc(1);
        chk_in = 1'b0;
        bad_in = 1'b0;
        cyc(4);
        chk("scan_halt", 16'h0001, {15'h0, halt});
        chk("active", 16'h0000, {15'h0, active});
        chk("fault_n", 16'h0000, {15'h0, fault_n});
        rd(6'h04, 14'h0400);
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
    initial begin
        cyc(10);
        rst_in = 1'b0;
        chk("comm timeout", 16'h007f, {9'h0, comm_to});
        chk("bal timeout", 16'h0000, {9'h0, bal_to});
        rd(6'h04, 14'h0000);
        rd(6'h05, 14'h0000);
        rd(6'h06, 14'h0000);
        rd(6'h13, 14'h0000);
        rd(6'h14, 14'h0000);
        rd(6'h15, 14'h007f);
        t_pins();
        t_details();
        t_force(14'h1000, 14'h1fff, 14'h3fff);
        t_force(14'h2000, 14'h2000, 14'h0000);
        t_force(14'h3000, 14'h0123, 14'h0456);
        t_force(14'h0000, 14'h0123, 14'h0456);
        t_read_all();
        t_balance();
        t_checksum();
        end_of_test();
    end
endmodule // fbsr_regs_tb
`default_nettype wire
